// file: hw/fic_capture_top.sv
// Purpose: time tagging of transitions on the fast input capture lines
// Assumes: capture lines synchronous to clk_i; one state time per clock
// Notes:   tags come from a timer that advances every 8 states
//          lost and overflow outputs are one-cycle pulses, not sticky
`timescale 1ns/1ps
module fic_capture_top (
    input  wire logic                          clk_i,
    input  wire logic                          sys_rst_i,
    input  wire logic [fic_pkg::LINES-1:0]     cap_line_i,
    input  wire logic                          hold_rd_i,
    output logic                               hold_valid_o,
    output logic [fic_pkg::LINES-1:0]          hold_lines_o,
    output logic [fic_pkg::TAG_W-1:0]          hold_tag_o,
    output logic [fic_pkg::TAG_W-1:0]          timer_o,
    output logic [fic_pkg::PTR_W:0]            fifo_count_o,
    output logic                               fifo_full_o,
    output logic                               event_lost_o,
    output logic                               overflow_o
);

    // ------------------------------------------------------------
    // event store
    // ------------------------------------------------------------
    // entries wait here until the holding register is free
    fic_fifo_if fifo_bus ();

    fic_fifo u_fifo (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .bus       (fifo_bus.store)
    );

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [fic_pkg::CNT_W-1:0]            tmr_div;
    logic [fic_pkg::CNT_W-1:0]            smp_div;
    logic [fic_pkg::CNT_W-1:0]            hold_wait;
    logic [fic_pkg::TAG_W-1:0]            timer;
    logic [fic_pkg::LINES-1:0]            line_prev;
    logic [fic_pkg::LINES-1:0]            pending;
    logic [fic_pkg::LINES-1:0]            hold_lines;
    logic [fic_pkg::TAG_W-1:0]            hold_tag;
    logic                                 event_lost;
    logic                                 overflow;
    fic_pkg::fic_hold_t                   hold_state;
    fic_pkg::fic_hold_t                   next_hold_state;

    // ------------------------------------------------------------
    // dividers
    // ------------------------------------------------------------
    wire timer_tick  = (tmr_div == fic_pkg::TIMER_DIV_LAST);
    wire sample_tick = (smp_div == fic_pkg::SAMPLE_DIV_LAST);

    // both dividers restart together at reset, which fixes the sampling phase
    wire [fic_pkg::CNT_W-1:0] next_tmr_div = timer_tick ? fic_pkg::DIV_RST : tmr_div + 1'b1;
    wire [fic_pkg::CNT_W-1:0] next_smp_div = sample_tick ? fic_pkg::DIV_RST : smp_div + 1'b1;
    wire [fic_pkg::TAG_W-1:0] next_timer   = timer_tick ? timer + 1'b1 : timer;

    // ------------------------------------------------------------
    // detection and sampling
    // ------------------------------------------------------------
    wire [fic_pkg::LINES-1:0] line_edge;
    wire [fic_pkg::LINES-1:0] sample_mask;
    wire [fic_pkg::LINES-1:0] next_pending;
    wire [fic_pkg::LINES-1:0] line_lost;

    for (genvar g = 0; g < fic_pkg::LINES; g++) begin : g_line
        // any transition on the line is an event
        assign line_edge[g]    = cap_line_i[g] ^ line_prev[g];
        assign sample_mask[g]  = sample_tick & pending[g];
        // a fresh edge wins over the clear of its own pending bit
        assign next_pending[g] = (pending[g] & ~sample_mask[g]) | line_edge[g];
        // a second edge on a line not yet sampled is merged, i.e. lost
        assign line_lost[g]    = line_edge[g] & pending[g] & ~sample_mask[g];
    end

    wire                      next_lost    = |line_lost;
    wire                      next_ovf     = fifo_bus.push & fifo_bus.full;

    // events of one sampling phase share the tag; the next phase sees the
    // next timer value the sampler reaches, which skips one value in nine
    assign fifo_bus.push          = |sample_mask;
    assign fifo_bus.push_data.lines = sample_mask;
    assign fifo_bus.push_data.tag   = timer;

    // ------------------------------------------------------------
    // holding register control
    // ------------------------------------------------------------
    wire hold_full  = (hold_state == fic_pkg::FIC_HOLD_FULL);
    wire read_pop   = hold_rd_i & hold_full & ~fifo_bus.empty;
    wire delay_pop  = ~hold_full & ~fifo_bus.empty &
                      (hold_wait == fic_pkg::HOLD_WAIT_LAST);

    assign fifo_bus.pop = read_pop | delay_pop;

    // the wait counter runs only while the first stored entry waits alone
    wire                      hold_wait_run  = ~hold_full & ~fifo_bus.empty & ~delay_pop;
    wire [fic_pkg::CNT_W-1:0] next_hold_wait = hold_wait_run ? hold_wait + 1'b1
                                                             : fic_pkg::DIV_RST;

    always_comb begin
        next_hold_state = hold_state;
        case (hold_state)
            fic_pkg::FIC_HOLD_EMPTY: begin
                if (delay_pop) begin
                    next_hold_state = fic_pkg::FIC_HOLD_FULL;
                end
            end
            fic_pkg::FIC_HOLD_FULL: begin
                if (hold_rd_i && fifo_bus.empty) begin
                    next_hold_state = fic_pkg::FIC_HOLD_EMPTY;
                end
            end
            default: begin
                next_hold_state = fic_pkg::FIC_HOLD_EMPTY;
            end
        endcase
    end

    // ------------------------------------------------------------
    // timer and dividers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            tmr_div <= fic_pkg::DIV_RST;
        end else begin
            tmr_div <= next_tmr_div;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            smp_div <= fic_pkg::DIV_RST;
        end else begin
            smp_div <= next_smp_div;
        end
    end

    // the tag timer runs free; it is seen only through tags and timer_o
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            timer <= fic_pkg::TIMER_RST;
        end else begin
            timer <= next_timer;
        end
    end

    // ------------------------------------------------------------
    // line capture
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            line_prev <= fic_pkg::LINES_RST;
            pending   <= fic_pkg::LINES_RST;
        end else begin
            line_prev <= cap_line_i;
            pending   <= next_pending;
        end
    end

    // status pulses last one cycle each
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            event_lost <= 1'b0;
            overflow   <= 1'b0;
        end else begin
            event_lost <= next_lost;
            overflow   <= next_ovf;
        end
    end

    // ------------------------------------------------------------
    // holding register
    // ------------------------------------------------------------
    // tracks whether the holding register carries an event
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            hold_state <= fic_pkg::FIC_HOLD_EMPTY;
        end else begin
            hold_state <= next_hold_state;
        end
    end

    // counts the states the first stored entry has waited
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            hold_wait <= fic_pkg::DIV_RST;
        end else begin
            hold_wait <= next_hold_wait;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            hold_lines <= fic_pkg::LINES_RST;
            hold_tag   <= fic_pkg::TIMER_RST;
        end else if (fifo_bus.pop) begin
            hold_lines <= fifo_bus.head.lines;
            hold_tag   <= fifo_bus.head.tag;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign hold_valid_o = hold_full;
    assign hold_lines_o = hold_lines;
    assign hold_tag_o   = hold_tag;
    assign timer_o      = timer;
    assign fifo_count_o = fifo_bus.count;
    assign fifo_full_o  = fifo_bus.full;
    assign event_lost_o = event_lost;
    assign overflow_o   = overflow;

endmodule // fic_capture_top

// file: hw/fic_fifo.sv
// Purpose: event store of the fast input capture unit
// Assumes: pop only while not empty
// Notes:   push while full is dropped
`timescale 1ns/1ps
module fic_fifo (
    input  wire logic    clk_i,
    input  wire logic    sys_rst_i,
    fic_fifo_if.store    bus
);

    fic_pkg::fic_entry_t                  mem [fic_pkg::FIFO_DEPTH];
    logic [fic_pkg::PTR_W-1:0]            wr_ptr;
    logic [fic_pkg::PTR_W-1:0]            rd_ptr;
    logic [fic_pkg::PTR_W:0]              count;

    wire do_push = bus.push & ~bus.full;
    wire do_pop  = bus.pop & ~bus.empty;

    assign bus.empty = (count == '0);
    assign bus.full  = (count == (fic_pkg::PTR_W+1)'(fic_pkg::FIFO_DEPTH));
    assign bus.head  = mem[rd_ptr];
    assign bus.count = count;

    always_ff @(posedge clk_i) begin
        if (do_push) begin
            mem[wr_ptr] <= bus.push_data;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (do_push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (do_pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (do_push && !do_pop) begin
                count <= count + 1'b1;
            end else if (do_pop && !do_push) begin
                count <= count - 1'b1;
            end
        end
    end

endmodule // fic_fifo

// file: hw/fic_fifo_if.sv
// Purpose: carrier between the capture core and its event store
// Assumes: single clock domain
// Notes:   push is ignored by the store while full
`timescale 1ns/1ps
interface fic_fifo_if;
    logic                                 push;
    fic_pkg::fic_entry_t                  push_data;
    logic                                 pop;
    fic_pkg::fic_entry_t                  head;
    logic                                 empty;
    logic                                 full;
    logic [fic_pkg::PTR_W:0]              count;

    modport core  (output push, output push_data, output pop,
                   input head, input empty, input full, input count);
    modport store (input push, input push_data, input pop,
                   output head, output empty, output full, output count);
endinterface

// file: hw/fic_pkg.sv
// Purpose: shared constants and types of the fast input capture unit
// Assumes: one state time equals whole clock cycles at 25 MHz
// Notes:   all timing counts derive from state times and the clock period
package fic_pkg;

    // ------------------------------------------------------------
    // structure
    // ------------------------------------------------------------
    localparam int LINES      = 4;
    localparam int TAG_W      = 16;
    localparam int FIFO_DEPTH = 8;
    localparam int PTR_W      = 3;
    localparam int CNT_W      = 4;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int STATE_TIME_NS = 40;
    localparam int STATE_CYCLES  = (STATE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TIMER_STATES  = 8;
    localparam int SAMPLE_STATES = 9;
    localparam int HOLD_STATES   = 8;
    localparam int TIMER_CYCLES  = TIMER_STATES * STATE_CYCLES;
    localparam int SAMPLE_CYCLES = SAMPLE_STATES * STATE_CYCLES;
    localparam int HOLD_CYCLES   = HOLD_STATES * STATE_CYCLES;

    localparam logic [CNT_W-1:0] TIMER_DIV_LAST  = CNT_W'(TIMER_CYCLES - 1);
    localparam logic [CNT_W-1:0] SAMPLE_DIV_LAST = CNT_W'(SAMPLE_CYCLES - 1);
    localparam logic [CNT_W-1:0] HOLD_WAIT_LAST  = CNT_W'(HOLD_CYCLES - 2);

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [TAG_W-1:0] TIMER_RST = 16'h0000;
    localparam logic [CNT_W-1:0] DIV_RST   = 4'h0;
    localparam logic [LINES-1:0] LINES_RST = 4'h0;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [LINES-1:0] lines;
        logic [TAG_W-1:0] tag;
    } fic_entry_t;

    typedef enum logic {
        FIC_HOLD_EMPTY,
        FIC_HOLD_FULL
    } fic_hold_t;

endpackage

// file: testbench/fic_capture_top_props.sv
// Purpose: port-level properties of the fast input capture unit
// Assumes: one clock domain, synchronous active-high reset
// Notes:   sees only the top module's ports; bound below
`timescale 1ns/1ps
module fic_capture_top_props (
    input wire logic                      clk_i,
    input wire logic                      sys_rst_i,
    input wire logic [fic_pkg::LINES-1:0] cap_line_i,
    input wire logic                      hold_rd_i,
    input wire logic                      hold_valid_o,
    input wire logic [fic_pkg::LINES-1:0] hold_lines_o,
    input wire logic [fic_pkg::TAG_W-1:0] hold_tag_o,
    input wire logic [fic_pkg::TAG_W-1:0] timer_o,
    input wire logic [fic_pkg::PTR_W:0]   fifo_count_o,
    input wire logic                      fifo_full_o,
    input wire logic                      event_lost_o,
    input wire logic                      overflow_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    property p_lost; event_lost_o |-> $past(cap_line_i) != $past(cap_line_i, 2); endproperty
    a_lost: assert property (p_lost) else $error("lost pulse without an edge");
    property p_space; fifo_count_o == $past(fifo_count_o) + 4'h1
        |=> (fifo_count_o <= $past(fifo_count_o)) [*8]; endproperty
    a_space: assert property (p_space) else $error("samples closer than 9 cycles");
    property p_timer; $changed(timer_o) |-> timer_o == $past(timer_o) + 16'h1
        ##1 $stable(timer_o) [*7] ##1 $changed(timer_o); endproperty
    a_timer: assert property (p_timer) else $error("timer step wrong");
    property p_delay; !hold_valid_o && fifo_count_o == 4'h0 ##1 fifo_count_o != 4'h0
        |-> !hold_valid_o [*7] ##1 hold_valid_o && fifo_count_o == 4'h0; endproperty
    a_delay: assert property (p_delay) else $error("holding load not 8 after push");
    property p_rtag; $rose(hold_valid_o) |-> timer_o == hold_tag_o + 16'h1; endproperty
    a_rtag: assert property (p_rtag) else $error("held tag not one below timer");
    property p_more; hold_valid_o && hold_rd_i && fifo_count_o != 4'h0 |=> hold_valid_o
        && fifo_count_o <= $past(fifo_count_o) && hold_tag_o != $past(hold_tag_o); endproperty
    a_more: assert property (p_more) else $error("head not advanced on read");
    property p_last; hold_valid_o && hold_rd_i && fifo_count_o == 4'h0 |=> !hold_valid_o;
    endproperty
    a_last: assert property (p_last) else $error("holding not emptied");
    property p_ovf; overflow_o |-> $past(fifo_full_o); endproperty
    a_ovf: assert property (p_ovf) else $error("overflow while not full");

    c_load: cover property ($rose(hold_valid_o));
    c_ovf: cover property (overflow_o);
    c_lost: cover property (event_lost_o);
endmodule // fic_capture_top_props

bind fic_capture_top fic_capture_top_props u_props (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .cap_line_i(cap_line_i), .hold_rd_i(hold_rd_i), .hold_valid_o(hold_valid_o),
    .hold_lines_o(hold_lines_o), .hold_tag_o(hold_tag_o), .timer_o(timer_o),
    .fifo_count_o(fifo_count_o), .fifo_full_o(fifo_full_o), .event_lost_o(event_lost_o),
    .overflow_o(overflow_o));

// file: testbench/fic_capture_top_tb.sv
// Purpose: self-checking bench of the fast input capture unit
// Assumes: cycle 0 follows the last reset edge; first sample tick in cycle 8
// Notes:   tag of a tick in cycle t is t/8
`timescale 1ns/1ps
module fic_capture_top_tb;
    logic                      clk_i;
    logic                      sys_rst_i;
    logic                      hold_rd_i;
    wire  [fic_pkg::LINES-1:0] cap_line, hold_lines;
    wire  [fic_pkg::TAG_W-1:0] hold_tag, timer;
    wire  [fic_pkg::PTR_W:0]   cnt;
    wire                       hold_valid, full, lost, ovf;
    int                        cyc = 0, errors = 0, n_compared = 0, n_lost = 0, n_ovf = 0;

    fic_event_src src (.cap_line_o(cap_line));
    fic_capture_top uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .cap_line_i(cap_line),
        .hold_rd_i(hold_rd_i), .hold_valid_o(hold_valid), .hold_lines_o(hold_lines),
        .hold_tag_o(hold_tag), .timer_o(timer), .fifo_count_o(cnt), .fifo_full_o(full),
        .event_lost_o(lost), .overflow_o(ovf));

    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    always @(posedge clk_i) cyc <= sys_rst_i ? 0 : cyc + 1;
    always @(negedge clk_i) begin
        if (lost === 1'b1) n_lost++;
        if (ovf === 1'b1) n_ovf++;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // first sample tick at or after cycle c
    function automatic int tick_at(input int c);
        return 8 + (c / 9) * 9;
    endfunction
    task automatic wait_to(input int k);
        while (cyc < k) @(negedge clk_i);
    endtask
    task automatic rd;
        @(negedge clk_i) hold_rd_i = 1'b1;
        @(negedge clk_i) hold_rd_i = 1'b0;
    endtask

    task automatic s_same_phase;
        int t;
        t = tick_at(cyc + 12);
        wait_to(t - 4);
        src.fire(4'h1);
        wait_to(t - 2);
        src.fire(4'h2);
        wait_to(t + 7);
        check(hold_valid, 0);
        wait_to(t + 8);
        check(hold_valid, 1);
        check(cnt, 0);
        check(hold_lines, 4'h3);
        check(hold_tag, t / 8);
        check(timer, (t + 8) / 8);
        rd;
        check(hold_valid, 0);
    endtask
    // phase steps by 2 ticks per pass, so the skipped value is crossed
    task automatic s_close;
        int t;
        for (int i = 0; i < 9; i++) begin
            t = tick_at(cyc + 4);
            wait_to(t - 1);
            src.fire(4'h4);
            wait_to(t + 5);
            src.fire(4'h8);
            wait_to(t + 8);
            check(hold_tag, t / 8);
            wait_to(t + 10);
            check(cnt, 1);
            rd;
            check(hold_tag, (t + 9) / 8);
            check(hold_lines, 4'h8);
            rd;
        end
    endtask
    task automatic s_lost;
        int t, n0;
        t = tick_at(cyc + 12);
        n0 = n_lost;
        wait_to(t - 6);
        src.fire(4'h1);
        wait_to(t - 3);
        src.fire(4'h1);
        wait_to(t + 8);
        check(n_lost - n0, 1);
        check(hold_lines, 4'h1);
        rd;
    endtask
    task automatic s_overflow;
        int t, n0;
        t = tick_at(cyc + 4);
        n0 = n_ovf;
        for (int i = 0; i < 10; i++) begin
            wait_to(t + 9 * i - 1);
            src.fire(4'h2);
        end
        wait_to(t + 83);
        check(full, 1);
        check(n_ovf - n0, 1);
        for (int i = 0; i < 9; i++) begin
            check(hold_tag, (t + 9 * i) / 8);
            rd;
        end
        check(hold_valid, 0);
    endtask

    task automatic end_of_test;
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        sys_rst_i = 1'b1;
        hold_rd_i = 1'b0;
        repeat (2) @(negedge clk_i);
        sys_rst_i = 1'b0;
        s_same_phase;
        s_close;
        s_lost;
        s_overflow;
        end_of_test;
    end
    initial begin
        #(40 * 3000);
        errors++;
        end_of_test;
    end
endmodule // fic_capture_top_tb

// file: testbench/fic_event_src.sv
// Purpose: external event source on the capture lines
// Assumes: caller invokes fire just after a falling clock edge
// Notes:   lines start low, matching the reset value of the edge detector
`timescale 1ns/1ps
module fic_event_src (
    output logic [fic_pkg::LINES-1:0] cap_line_o
);
    initial cap_line_o = 4'h0;
    // every flip is one event on that line
    task automatic fire(input logic [fic_pkg::LINES-1:0] mask);
        cap_line_o = cap_line_o ^ mask;
    endtask
endmodule // fic_event_src
